// file: verilog/dsp_regfile.v
// dsp status, repeat, modulo and core control register state with data format helpers
// assumes single clock, synchronous active-high reset acting as power-on reset
// Contract
// - dsp status bits 31..8 read zero
// - bit 7 set on positive or greater
// - bit 6 set on zero or equal
// - bit 5 set on negative or smaller
// - bit 4 set on overflow
// - bits 3..1 select condition source
// - bit 0 reflects selected condition
// - loops use count, start, end registers
// - modulo register holds end high, start low
// - modulo wrap only on x/y transfers
// - status word reset pattern fixed
// - vector base, dsp status zero; pc a0000000
// - byte/word loads sign-extended to 32
// - misaligned word/long raises address error
// - endian sampled on first clock after reset, fixed after
// - immediates sign or zero extended by op
// - fixed-point point between bits 31,30
// - integer point between bits 16,15
// - arith shift seven bits, valid -32..32
// - logical shift six bits, valid -16..16
// - conditional ops never update status
`timescale 1ns/1ps
`default_nettype none
`include "dsp_regs_map.vh"
module dsp_regfile (
    input  wire        clk,
    input  wire        rst,
    input  wire        endian_select_pin,
    input  wire        dsr_wr,
    input  wire [31:0] dsr_wdata,
    input  wire        sr_wr,
    input  wire [31:0] sr_wdata,
    input  wire        vbr_wr,
    input  wire [31:0] vbr_wdata,
    input  wire        pc_wr,
    input  wire [31:0] pc_wdata,
    input  wire        rs_wr,
    input  wire [31:0] rs_wdata,
    input  wire        re_wr,
    input  wire [31:0] re_wdata,
    input  wire        mod_wr,
    input  wire [31:0] mod_wdata,
    input  wire        op_valid,
    input  wire        op_cond,
    input  wire        op_cmp,
    input  wire [31:0] op_a,
    input  wire [31:0] op_b,
    input  wire [31:0] op_result,
    input  wire        op_ovf,
    input  wire        op_carry,
    input  wire        xfer_valid,
    input  wire        xfer_is_xy,
    input  wire        xfer_is_y,
    input  wire [15:0] xfer_addr,
    input  wire [31:0] mem_addr,
    input  wire [1:0]  mem_size,
    input  wire        mem_valid,
    input  wire [31:0] load_raw,
    input  wire [7:0]  imm_byte,
    input  wire        imm_zero_ext,
    input  wire [6:0]  ash_amount,
    input  wire [5:0]  lsh_amount,
    input  wire [31:0] fix_data,
    output wire [31:0] dsr_rdata,
    output wire [31:0] sr_rdata,
    output wire [31:0] vbr_rdata,
    output wire [31:0] pc_rdata,
    output wire [31:0] rs_rdata,
    output wire [31:0] re_rdata,
    output wire [31:0] mod_rdata,
    output wire        dsp_condition_bit,
    output wire        exec_enable,
    output wire [11:0] repeat_count,
    output wire        x_modulo_enable,
    output wire        y_modulo_enable,
    output wire [15:0] xfer_addr_wrapped,
    output reg         addr_error,
    output wire [31:0] load_ext,
    output wire [31:0] imm_ext,
    output wire        little_endian,
    output wire        ash_valid,
    output wire        lsh_valid,
    output wire        fix_sign,
    output wire [30:0] fix_frac,
    output wire [15:0] int_part,
    output wire [15:0] int_frac
);
    reg  [7:0]  dsr_reg;
    reg  [7:0]  dsr_next;
    reg  [31:0] sr_reg;
    reg  [31:0] vbr_reg;
    reg  [31:0] pc_reg;
    reg  [31:0] rs_reg;
    reg  [31:0] re_reg;
    reg  [31:0] mod_reg;
    reg         endian_reg;
    reg         sampled_reg;
    wire [15:0] modulo_end_addr;
    wire [15:0] modulo_start_addr;
    wire        res_zero;
    wire        res_neg;
    wire        f_gt;
    wire        f_z;
    wire        f_n;
    wire        cond_ge;
    reg         dc_sel;

    assign res_zero = (op_result == 32'h00000000);
    assign res_neg  = op_result[31];
    assign f_gt = op_cmp ? ($signed(op_a) > $signed(op_b)) : (!res_neg && !res_zero);
    assign f_z  = op_cmp ? (op_a == op_b) : res_zero;
    assign f_n  = op_cmp ? ($signed(op_a) < $signed(op_b)) : res_neg;
    assign cond_ge = !(f_n ^ op_ovf);

    always @* begin
        case (dsr_reg[`CS_HI:`CS_LO])
            `CS_CARRY: dc_sel = op_carry;
            `CS_NEG:   dc_sel = f_n;
            `CS_ZERO:  dc_sel = f_z;
            `CS_OVF:   dc_sel = op_ovf;
            `CS_GT:    dc_sel = f_gt && !op_ovf;
            `CS_GE:    dc_sel = cond_ge;
            default:   dc_sel = 1'b0;
        endcase
    end

    always @* begin
        dsr_next = dsr_reg;
        if (dsr_wr) begin
            dsr_next = dsr_wdata[7:0];
        end else if (op_valid && !op_cond) begin
            dsr_next[`GT_BIT] = f_gt;
            dsr_next[`Z_BIT]  = f_z;
            dsr_next[`N_BIT]  = f_n;
            dsr_next[`V_BIT]  = op_ovf;
            dsr_next[`DC_BIT] = dc_sel;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            dsr_reg <= 8'h00;
            sr_reg  <= `SR_RESET;
            vbr_reg <= `VBR_RESET;
            pc_reg  <= `PC_RESET;
            rs_reg  <= 32'h00000000;
            re_reg  <= 32'h00000000;
            mod_reg <= 32'h00000000;
            sampled_reg <= 1'b0;
            endian_reg  <= 1'b0;
        end else begin
            dsr_reg <= dsr_next;
            if (sr_wr) sr_reg <= sr_wdata;
            if (vbr_wr) vbr_reg <= vbr_wdata;
            if (pc_wr) pc_reg <= pc_wdata;
            if (rs_wr) rs_reg <= rs_wdata;
            if (re_wr) re_reg <= re_wdata;
            if (mod_wr) mod_reg <= mod_wdata;
            if (!sampled_reg) begin
                endian_reg  <= endian_select_pin;
                sampled_reg <= 1'b1;
            end
        end
    end

    assign dsr_rdata = {24'h000000, dsr_reg};
    assign dsp_condition_bit = dsr_reg[`DC_BIT];
    assign exec_enable = !op_cond || dsr_reg[`DC_BIT];
    assign sr_rdata  = sr_reg;
    assign vbr_rdata = vbr_reg;
    assign pc_rdata  = pc_reg;
    assign rs_rdata  = rs_reg;
    assign re_rdata  = re_reg;
    assign mod_rdata = mod_reg;
    assign little_endian = endian_reg;
    assign repeat_count    = sr_reg[`SR_RC_HI:`SR_RC_LO];
    assign x_modulo_enable = sr_reg[`SR_DMX_BIT];
    assign y_modulo_enable = sr_reg[`SR_DMY_BIT];

    assign modulo_end_addr   = mod_reg[31:16];
    assign modulo_start_addr = mod_reg[15:0];
    // wrap to start when the pointer sits on the end address
    assign xfer_addr_wrapped = (xfer_valid && xfer_is_xy &&
                                (xfer_is_y ? y_modulo_enable : x_modulo_enable) &&
                                xfer_addr == modulo_end_addr) ? modulo_start_addr : xfer_addr;

    always @* begin
        addr_error = 1'b0;
        if (mem_valid) begin
            if (mem_size == `SZ_WORD) addr_error = mem_addr[0];
            else if (mem_size == `SZ_LONG) addr_error = |mem_addr[1:0];
        end
    end

    ext_unit load_ext_u (
        .raw      (load_raw),
        .size     (mem_size),
        .zero_ext (1'b0),
        .ext      (load_ext)
    );

    ext_unit imm_ext_u (
        .raw      ({24'h000000, imm_byte}),
        .size     (`SZ_BYTE),
        .zero_ext (imm_zero_ext),
        .ext      (imm_ext)
    );

    assign ash_valid = ($signed(ash_amount) >= $signed(`ASH_MIN)) &&
                       ($signed(ash_amount) <= $signed(`ASH_MAX));
    assign lsh_valid = ($signed(lsh_amount) >= $signed(`LSH_MIN)) &&
                       ($signed(lsh_amount) <= $signed(`LSH_MAX));
    assign fix_sign = fix_data[31];
    assign fix_frac = fix_data[30:0];
    assign int_part = fix_data[31:16];
    assign int_frac = fix_data[15:0];
endmodule
`default_nettype wire

// file: include/dsp_regs_map.vh
// constants for the dsp status / control register file
// assumes inclusion by bare name from design files
`ifndef DSP_REGS_MAP_VH
`define DSP_REGS_MAP_VH
`define GT_BIT        7
`define Z_BIT         6
`define N_BIT         5
`define V_BIT         4
`define CS_HI         3
`define CS_LO         1
`define DC_BIT        0
`define CS_CARRY      3'h0
`define CS_NEG        3'h1
`define CS_ZERO       3'h2
`define CS_OVF        3'h3
`define CS_GT         3'h4
`define CS_GE         3'h5
`define DSR_RESET     32'h00000000
`define DSR_WMASK     32'h000000ff
`define VBR_RESET     32'h00000000
`define PC_RESET      32'ha0000000
`define SR_RESET      32'h70003c00
`define SR_MD_BIT     30
`define SR_RB_BIT     29
`define SR_BL_BIT     28
`define SR_RC_HI      27
`define SR_RC_LO      16
`define SR_DMY_BIT    11
`define SR_DMX_BIT    10
`define SR_F_HI       13
`define SR_F_LO       10
`define SZ_BYTE       2'h0
`define SZ_WORD       2'h1
`define SZ_LONG       2'h2
`define IMM_SIGN      1'b0
`define IMM_ZERO      1'b1
`define ASH_MIN       7'h60
`define ASH_MAX       7'h20
`define LSH_MIN       6'h30
`define LSH_MAX       6'h10
`endif

// file: verilog/ext_unit.v
// load-data and immediate extension unit
// assumes size code from the map header
`timescale 1ns/1ps
`default_nettype none
`include "dsp_regs_map.vh"
module ext_unit (
    input  wire [31:0] raw,
    input  wire [1:0]  size,
    input  wire        zero_ext,
    output reg  [31:0] ext
);
    always @* begin
        if (size == `SZ_BYTE) begin
            ext = zero_ext ? {24'h000000, raw[7:0]} : {{24{raw[7]}}, raw[7:0]};
        end else if (size == `SZ_WORD) begin
            ext = zero_ext ? {16'h0000, raw[15:0]} : {{16{raw[15]}}, raw[15:0]};
        end else begin
            ext = raw;
        end
    end
endmodule
`default_nettype wire

// file: testbench/dsp_regfile_monitor.sv
// checker for the dsp register file ports
// assumes a bind onto dsp_regfile, one clock domain
`timescale 1ns/1ps
`default_nettype none
module dsp_regfile_monitor (
    input wire logic        clk, rst, dsr_wr, op_valid, op_cond, op_cmp, op_ovf,
    input wire logic        mem_valid, dsp_condition_bit, addr_error,
    input wire logic [31:0] op_a, op_b, op_result, mem_addr, dsr_rdata, pc_rdata,
    input wire logic [1:0]  mem_size
);
    wire logic upd = op_valid && !op_cond && !dsr_wr;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_rsvd_zero: assert property (dsr_rdata[31:8] == 24'h000000)
        else $error("dsr upper bits set");
    chk_reset_vals: assert property ($fell(rst) |-> dsr_rdata == 32'h0 && pc_rdata == 32'ha0000000)
        else $error("reset values wrong");
    chk_cond_hold: assert property (op_valid && op_cond && !dsr_wr |=> $stable(dsr_rdata))
        else $error("conditional op changed dsr");
    chk_gt_cmp: assert property (upd && op_cmp |=> dsr_rdata[7] == ($signed($past(op_a)) > $signed($past(op_b))))
        else $error("greater flag wrong");
    chk_zero_flag: assert property (upd && !op_cmp |=> dsr_rdata[6] == ($past(op_result) == 32'h0))
        else $error("zero flag wrong");
    chk_neg_ovf: assert property (upd && !op_cmp |=> dsr_rdata[5:4] == {$past(op_result[31]), $past(op_ovf)})
        else $error("negative or overflow flag wrong");
    chk_dc_zero: assert property (upd && dsr_rdata[3:1] == 3'h2 |=> dsp_condition_bit == dsr_rdata[6])
        else $error("condition bit wrong");
    chk_align_err: assert property (mem_valid |-> addr_error == ((mem_size == 2'h1 && mem_addr[0])
        || (mem_size == 2'h2 && mem_addr[1:0] != 2'h0)))
        else $error("address error wrong");
endmodule
bind dsp_regfile dsp_regfile_monitor u_mon (.clk(clk), .rst(rst), .dsr_wr(dsr_wr), .op_valid(op_valid),
    .op_cond(op_cond), .op_cmp(op_cmp), .op_ovf(op_ovf), .mem_valid(mem_valid), .addr_error(addr_error),
    .dsp_condition_bit(dsp_condition_bit), .op_a(op_a), .op_b(op_b), .op_result(op_result),
    .mem_addr(mem_addr), .dsr_rdata(dsr_rdata), .pc_rdata(pc_rdata), .mem_size(mem_size));
`default_nettype wire

// file: testbench/dsp_regfile_test.sv
// directed bench for the dsp register file
// assumes dsp_regfile and its map header on the include path
`timescale 1ns/1ps
`default_nettype none
module dsp_regfile_test;
    reg clk, rst, pin, vld, cnd, cmp, ovf, xv, xxy, mv, izx;
    reg [6:0] we, ash;
    reg [31:0] w, a, b, res, maddr, raw, fix;
    reg [1:0] sz;
    reg [15:0] xa, ip;
    reg [7:0] imm;
    reg [5:0] lsh;
    wire [31:0] d_o, sr_o, vb_o, pc_o, rs_o, re_o, md_o, lx, ix;
    wire [15:0] xw, ipo, ifr;
    wire [30:0] ff;
    wire dc, ee, xe, ae, le, av, lv, fs;
    integer failures, check_count, i;
    dsp_regfile u_dut (.clk(clk), .rst(rst), .endian_select_pin(pin), .dsr_wr(we[0]), .dsr_wdata(w),
        .sr_wr(we[1]), .sr_wdata(w), .vbr_wr(we[2]), .vbr_wdata(w), .pc_wr(we[3]), .pc_wdata(w),
        .rs_wr(we[4]), .rs_wdata(w), .re_wr(we[5]), .re_wdata(w), .mod_wr(we[6]), .mod_wdata(w),
        .op_valid(vld), .op_cond(cnd), .op_cmp(cmp), .op_a(a), .op_b(b), .op_result(res), .op_ovf(ovf),
        .op_carry(1'b1), .xfer_valid(xv), .xfer_is_xy(xxy), .xfer_is_y(1'b0), .xfer_addr(xa),
        .mem_addr(maddr), .mem_size(sz), .mem_valid(mv), .load_raw(raw), .imm_byte(imm),
        .imm_zero_ext(izx), .ash_amount(ash), .lsh_amount(lsh), .fix_data(fix), .dsr_rdata(d_o),
        .sr_rdata(sr_o), .vbr_rdata(vb_o), .pc_rdata(pc_o), .rs_rdata(rs_o), .re_rdata(re_o),
        .mod_rdata(md_o), .dsp_condition_bit(dc), .exec_enable(ee), .repeat_count(), .x_modulo_enable(xe),
        .y_modulo_enable(), .xfer_addr_wrapped(xw), .addr_error(ae), .load_ext(lx), .imm_ext(ix),
        .little_endian(le), .ash_valid(av), .lsh_valid(lv), .fix_sign(fs), .fix_frac(ff),
        .int_part(ipo), .int_frac(ifr));
    task chk(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("ERROR %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task close_out;
        begin
            $display("checks %0d failures %0d", check_count, failures);
            if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task wr(input integer k, input [31:0] v);
        begin
            w = v;
            we[k] = 1'b1;
            @(negedge clk) we[k] = 1'b0;
            @(negedge clk);
        end
    endtask
    task op(input c, input p, input [31:0] r, input [31:0] x, input [31:0] y);
        begin
            {cnd, cmp, res, a, b, vld} = {c, p, r, x, y, 1'b1};
            @(negedge clk) vld = 1'b0;
            @(negedge clk);
        end
    endtask
    task t_reset;
        begin
            chk(d_o, 32'h0);
            chk(sr_o, 32'h70003c00);
            chk(vb_o, 32'h0);
            chk(pc_o, 32'ha0000000);
            pin = 1'b0;
            repeat (3) @(negedge clk);
            chk({31'h0, le}, 32'h1);
        end
    endtask
    task t_flags;
        begin
            wr(0, 32'hffffffff);
            chk(d_o, 32'h000000ff);
            wr(0, 32'h00000008);
            op(0, 1, 0, 5, 3);
            chk(d_o, 32'h89);
            op(0, 1, 0, 7, 7);
            chk(d_o, 32'h48);
            op(0, 1, 0, 32'hffffffff, 2);
            chk(d_o, 32'h28);
            op(1, 0, 32'h0, 0, 0);
            chk(d_o, 32'h28);
            chk({31'h0, ee}, 32'h0);
            for (i = 0; i < 6; i = i + 1) begin
                wr(0, i << 1);
                op(0, 0, 32'h80000000, 0, 0);
                chk(d_o, 32'h20 | (i << 1) | (i < 2));
            end
            ovf = 1'b1;
            wr(0, 32'h6);
            op(0, 0, 32'h0, 0, 0);
            chk(d_o, 32'h57);
            ovf = 1'b0;
        end
    endtask
    task t_data;
        begin
            {sz, raw, imm, izx, mv} = {2'h0, 32'h12345680, 8'h80, 1'b0, 1'b1};
            #1 chk(lx, 32'hffffff80);
            chk(ix, 32'hffffff80);
            {sz, raw, izx} = {2'h1, 32'h00008001, 1'b1};
            #1 chk(lx, 32'hffff8001);
            chk(ix, 32'h00000080);
            for (i = 0; i < 12; i = i + 1) begin
                @(negedge clk) {sz, maddr} = {i[3:2], 30'h0, i[1:0]};
            end
            #1 chk({31'h0, ae}, 32'h1);
            {mv, ash, lsh, fix} = {1'b0, 7'h20, 6'h11, 32'h80000003};
            #1 chk({29'h0, av, lv, fs}, 32'h5);
            chk({1'b0, ff}, 32'h00000003);
            chk({ipo, ifr}, 32'h80000003);
            {ash, lsh} = {7'h21, 6'h10};
            #1 chk({30'h0, av, lv}, 32'h1);
        end
    endtask
    task t_mod;
        begin
            wr(4, 32'h00001234);
            wr(5, 32'h00005678);
            chk(rs_o ^ re_o, 32'h0000444c);
            wr(6, 32'h01000010);
            wr(1, 32'h00000400);
            chk(md_o, 32'h01000010);
            {xv, xxy, xa} = {1'b1, 1'b1, 16'h0100};
            #1 chk({xe, xw}, {1'b1, 16'h0010});
            xxy = 1'b0;
            #1 chk({16'h0, xw}, 32'h0100);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        {rst, pin, vld, cnd, cmp, ovf, xv, xxy, mv, izx, we, ash, lsh} = {2'b11, 28'h0};
        {w, a, b, res, maddr, raw, fix, sz, xa, imm} = 0;
        failures = 0;
        check_count = 0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_reset;
        t_flags;
        t_data;
        t_mod;
        close_out;
    end
    initial begin
        repeat (5000) @(posedge clk);
        failures = failures + 1;
        close_out;
    end
endmodule
`default_nettype wire
